/* dsw_pkg.sv */
package dsw_pkg;
    // resolution variants
    localparam int unsigned RES_12         = 12;
    localparam int unsigned RES_14         = 14;
    localparam int unsigned RES_16         = 16;
    // frame lengths in falling edges
    localparam int unsigned FRAME_LONG     = 24;
    localparam int unsigned FRAME_SHORT    = 16;
    localparam int unsigned SHIFT_W        = 24;
    localparam int unsigned CODE_W         = 16;
    localparam int unsigned CNT_W          = 5;
    // host-side clock ceilings, in MHz
    localparam int unsigned SCLK_MAX_HI_MHZ = 30;
    localparam int unsigned SCLK_MAX_LO_MHZ = 20;
    // reset values
    localparam logic [CODE_W-1:0]  CODE_RST  = 16'h0000;
    localparam logic [SHIFT_W-1:0] SHIFT_RST = 24'h000000;
    localparam logic [CNT_W-1:0]   CNT_RST   = 5'h00;
    localparam logic [1:0]         SYNC_RST  = 2'h3;
    localparam logic [1:0]         RST_SYNC0 = 2'h0;
    localparam logic [1:0]         RST_SYNC1 = 2'h3;

    typedef enum logic [1:0] {
        DSW_IDLE,
        DSW_SHIFT,
        DSW_WAIT
    } dsw_state_t;

    // number of falling edges that closes a frame
    function automatic logic [CNT_W-1:0] frame_len(input int unsigned res);
        frame_len = (res == RES_16) ? CNT_W'(FRAME_LONG) : CNT_W'(FRAME_SHORT);
    endfunction

    // largest straight-binary code of a variant
    function automatic logic [CODE_W-1:0] code_max(input int unsigned res);
        code_max = CODE_W'((17'h10000 >> (RES_16 - res)) - 17'h1);
    endfunction
endpackage

/* dsw_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// two-flop synchroniser for one pin
module dsw_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic d,
    output var  logic q
);
    import dsw_pkg::*;

    typedef struct packed {
        logic [1:0] ff;
    } dsw_sync_st_t;

    dsw_sync_st_t st_r;
    dsw_sync_st_t st_nxt;

    always_comb begin
        st_nxt.ff = {st_r.ff[0], d};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.ff <= SYNC_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.ff[1];
endmodule
`default_nettype wire

/* dsw_port.sv */
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - frame select low enables the shift register
// - shift data in on serial clock falls
// - update DAC at final falling edge
// - early frame select rise aborts, no update
// - shift register 24 bits wide, frame 24 or 16 bits long
// - loaded code is straight binary
module dsw_port #(
    parameter int unsigned RES = dsw_pkg::RES_16
) (
    clk,
    nrst,
    sync_n,
    sclk,
    din,
    dac_code,
    dac_load,
    frame_abort,
    busy
);
    import dsw_pkg::*;

    input  wire logic              clk;
    input  wire logic              nrst;
    input  wire logic              sync_n;
    input  wire logic              sclk;
    input  wire logic              din;
    output var  logic [CODE_W-1:0] dac_code;
    output var  logic              dac_load;
    output var  logic              frame_abort;
    output var  logic              busy;

    localparam logic [CNT_W-1:0]  FLEN = frame_len(RES);
    localparam logic [CODE_W-1:0] CMAX = code_max(RES);

    // =========================================================
    // reset release and pin synchronisers
    // =========================================================
    logic [1:0] rst_ff_r;
    logic       rst_n;
    logic       sync_n_s;
    logic       sclk_s;
    logic       din_s;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_ff_r <= RST_SYNC0;
        end else begin
            rst_ff_r <= {rst_ff_r[0], 1'b1};
        end
    end
    assign rst_n = rst_ff_r[1];

    dsw_sync u_sync_sel (.clk(clk), .rst_n(rst_n), .d(sync_n), .q(sync_n_s));
    dsw_sync u_sync_clk (.clk(clk), .rst_n(rst_n), .d(sclk),   .q(sclk_s));
    dsw_sync u_sync_din (.clk(clk), .rst_n(rst_n), .d(din),    .q(din_s));

    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        dsw_state_t         state;
        logic               sclk_d;
        logic               sel_d;
        logic [CNT_W-1:0]   cnt;
        logic [SHIFT_W-1:0] shreg;
        logic [CODE_W-1:0]  code;
        logic               load;
        logic               abort;
    } dsw_st_t;

    dsw_st_t st_r;
    dsw_st_t st_nxt;
    logic    sclk_fall;
    logic    sel_fall;
    logic    sel_rise;
    logic    last_fall;
    logic [SHIFT_W-1:0] shift_in;

    assign sclk_fall = st_r.sclk_d & ~sclk_s;
    assign sel_fall  = st_r.sel_d & ~sync_n_s;
    assign sel_rise  = ~st_r.sel_d & sync_n_s;
    assign shift_in  = {st_r.shreg[SHIFT_W-2:0], din_s};
    // final fall of the frame for this variant
    assign last_fall = sclk_fall && (st_r.cnt == FLEN - CNT_W'(1));

    // low bits of the last word carry the code; upper bits are control
    function automatic logic [CODE_W-1:0] extract(input logic [SHIFT_W-1:0] w);
        logic [CODE_W-1:0] raw;
        raw = w[CODE_W-1:0];
        extract = raw & CMAX;
    endfunction

    always_comb begin
        st_nxt        = st_r;
        st_nxt.sclk_d = sclk_s;
        st_nxt.sel_d  = sync_n_s;
        st_nxt.load   = 1'b0;
        st_nxt.abort  = 1'b0;
        unique case (st_r.state)
            DSW_IDLE: begin
                if (sel_fall) begin
                    st_nxt.state = DSW_SHIFT;
                    st_nxt.cnt   = CNT_RST;
                end
            end
            DSW_SHIFT: begin
                // final edge loads, even with select rising alongside
                if (last_fall) begin
                    st_nxt.shreg = shift_in;
                    st_nxt.code  = extract(shift_in);
                    st_nxt.load  = 1'b1;
                    st_nxt.cnt   = CNT_RST;
                    // a rise seen now would never show as an edge in wait
                    st_nxt.state = sync_n_s ? DSW_IDLE : DSW_WAIT;
                end else if (sync_n_s) begin
                    st_nxt.state = DSW_IDLE;
                    st_nxt.cnt   = CNT_RST;
                    st_nxt.abort = 1'b1;
                end else if (sclk_fall) begin
                    st_nxt.shreg = shift_in;
                    st_nxt.cnt   = st_r.cnt + CNT_W'(1);
                end
            end
            DSW_WAIT: begin
                if (sel_rise) begin
                    st_nxt.state = DSW_IDLE;
                end
            end
            default: begin
                st_nxt.state = DSW_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r.state  <= DSW_IDLE;
            st_r.sclk_d <= 1'b1;
            st_r.sel_d  <= 1'b1;
            st_r.cnt    <= CNT_RST;
            st_r.shreg  <= SHIFT_RST;
            st_r.code   <= CODE_RST;
            st_r.load   <= 1'b0;
            st_r.abort  <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dac_code    = st_r.code;
    assign dac_load    = st_r.load;
    assign frame_abort = st_r.abort;
    assign busy        = (st_r.state == DSW_SHIFT);

    // =========================================================
    // checks
    // =========================================================
    chk_load_on_edge: assert property (
        @(posedge clk) disable iff (!rst_n)
        dac_load |-> $past(sclk_fall) && $past(st_r.cnt) == FLEN - CNT_W'(1))
        else $error("load without final falling edge");

    chk_abort_keeps_code: assert property (
        @(posedge clk) disable iff (!rst_n)
        frame_abort |-> $stable(dac_code) && !dac_load)
        else $error("abort changed code");

    chk_code_stable: assert property (
        @(posedge clk) disable iff (!rst_n)
        !dac_load |-> $stable(dac_code))
        else $error("code moved without load");

    chk_shift_on_fall: assert property (
        @(posedge clk) disable iff (!rst_n)
        (busy && !sync_n_s && sclk_fall && st_r.cnt != FLEN - CNT_W'(1)) |=>
            st_r.shreg[0] == $past(din_s) && st_r.cnt == $past(st_r.cnt) + CNT_W'(1))
        else $error("bit not shifted on fall");

    chk_idle_ignores: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_r.state != DSW_SHIFT) |=> $stable(st_r.shreg))
        else $error("shift outside frame");

    chk_cnt_bound: assert property (
        @(posedge clk) disable iff (!rst_n)
        st_r.cnt < FLEN)
        else $error("counter past frame length");

    chk_code_range: assert property (
        @(posedge clk) disable iff (!rst_n)
        dac_code <= CMAX)
        else $error("code above full scale");

    chk_sel_enables: assert property (
        @(posedge clk) disable iff (!rst_n)
        (st_r.state == DSW_IDLE && sel_fall) |=> busy)
        else $error("frame select did not enable");

    cov_full_frame: cover property (@(posedge clk) disable iff (!rst_n) dac_load);
    cov_abort:      cover property (@(posedge clk) disable iff (!rst_n) frame_abort);
    chk_frame_end_clears: assert property (
        @(posedge clk) disable iff (!rst_n)
        (dac_load || frame_abort) |-> !busy && st_r.cnt == CNT_RST)
        else $error("frame end left counter or busy set");

    cov_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
        dac_load ##[1:1000] dac_load);
    cov_tight_close:  cover property (@(posedge clk) disable iff (!rst_n)
        dac_load && st_r.state == DSW_IDLE);
    cov_wait_ignores: cover property (@(posedge clk) disable iff (!rst_n)
        st_r.state == DSW_WAIT && sclk_fall);
endmodule
`default_nettype wire

/* dsw_host.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========
// host model: drives the three-wire write link off clk falls
module dsw_host (
    input  wire logic clk,
    output var  logic sync_n,
    output var  logic sclk,
    output var  logic din
);
    initial begin
        sync_n = 1'b1;
        sclk   = 1'b1;
        din    = 1'b0;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge clk);
    endtask
    // ==========
    // frame of n bits, msb first; stop from 0 to n-1 ends it early
    // stop below zero lifts select together with the final fall
    // 400 ns period, far under the ceiling
    task automatic send(input logic [23:0] w, input int n, input int stop);
        sync_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            din = w[n-1-i];
            hw(4);
            if (i == stop) break;
            sclk = 1'b0;
            // select may rise with the final fall
            if (stop < 0 && i == n - 1) begin
                sync_n = 1'b1;
            end
            hw(4);
            sclk = 1'b1;
        end
        hw(4);
        sync_n = 1'b1;
        // released line must not keep its last value
        din = ~din;
        hw(8);
    endtask
    task automatic idle(input int k);
        din = 1'b1;
        repeat (k) begin
            sclk = 1'b0;
            hw(4);
            sclk = 1'b1;
            hw(4);
        end
    endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dsw_pkg::*;
    typedef struct {
        logic [23:0] w;
        int          n;
        int          stop;
        logic [15:0] e16;
        logic [15:0] e12;
        logic        a16;
        logic        a12;
    } dsw_row_t;
    logic        clk, nrst, sync_n, sclk, din;
    logic        ld16, ld12, ab16, ab12;
    logic [15:0] code16, code12, code14;
    logic        bz16, bz12, bz14;
    logic [3:0]  nl16, nl12, na16, na12, l16, l12, b16, b12;
    int          fail_count, check_count, cyc;
    dsw_row_t    rows [6] = '{
        '{24'h00abcd, 24, 99, 16'habcd, 16'h00ab, 1'b0, 1'b0},
        '{24'h12ffff, 24, 99, 16'hffff, 16'h02ff, 1'b0, 1'b0},
        '{24'h005a3c, 16, 99, 16'hffff, 16'h0a3c, 1'b1, 1'b0},
        '{24'h000000, 24, 99, 16'h0000, 16'h0000, 1'b0, 1'b0},
        '{24'h876543, 24, 23, 16'h0000, 16'h0765, 1'b1, 1'b0},
        '{24'h0003ff, 24, 9,  16'h0000, 16'h0765, 1'b1, 1'b1}};
    dsw_host host (.clk(clk), .sync_n(sync_n), .sclk(sclk), .din(din));
    dsw_port #(.RES(RES_16)) dut (.clk(clk), .nrst(nrst), .sync_n(sync_n),
        .sclk(sclk), .din(din), .dac_code(code16), .dac_load(ld16),
        .frame_abort(ab16), .busy(bz16));
    dsw_port #(.RES(RES_12)) dut12 (.clk(clk), .nrst(nrst), .sync_n(sync_n),
        .sclk(sclk), .din(din), .dac_code(code12), .dac_load(ld12),
        .frame_abort(ab12), .busy(bz12));
    dsw_port #(.RES(RES_14)) dut14 (.clk(clk), .nrst(nrst), .sync_n(sync_n),
        .sclk(sclk), .din(din), .dac_code(code14), .dac_load(),
        .frame_abort(), .busy(bz14));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial {nl16, nl12, na16, na12, cyc} = '0;
    always @(posedge clk) begin
        nl16 <= nl16 + 4'(ld16 === 1'b1);
        nl12 <= nl12 + 4'(ld12 === 1'b1);
        na16 <= na16 + 4'(ab16 === 1'b1);
        na12 <= na12 + 4'(ab12 === 1'b1);
        cyc  <= cyc + 1;
        // whole run needs about 1700 cycles
        if (cyc == 5000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========
    // main sequence
    initial begin
        nrst = 1'b0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        chk(code16 | code12 | code14, CODE_RST);
        repeat (5) @(negedge clk);
        foreach (rows[k]) begin
            {l16, l12, b16, b12} = {nl16, nl12, na16, na12};
            host.send(rows[k].w, rows[k].n, rows[k].stop);
            chk(code16, rows[k].e16);
            chk(code12, rows[k].e12);
            chk({nl16 - l16, na16 - b16, nl12 - l12, na12 - b12},
                {3'h0, !rows[k].a16, 3'h0, rows[k].a16,
                 3'h0, !rows[k].a12, 3'h0, rows[k].a12});
            chk({13'h0, bz16, bz12, bz14}, 16'h0000);
            $display("row %0d done", k);
        end
        {l16, l12, b16, b12} = {nl16, nl12, na16, na12};
        host.idle(4);
        chk(code12, 16'h0765);
        chk(code16, 16'h0000);
        chk({nl16 - l16, na16 - b16, nl12 - l12, na12 - b12}, 16'h0000);
        $display("deselected clocks done");
        nrst = 1'b0;
        repeat (2) @(negedge clk);
        chk(code16 | code12 | code14, CODE_RST);
        nrst = 1'b1;
        repeat (5) @(negedge clk);
        fork
            host.send(24'h001234, 24, 99);
            begin
                repeat (20) @(negedge clk);
                chk({13'h0, bz16, bz12, bz14}, 16'h0007);
            end
        join
        chk(code16, 16'h1234);
        chk(code12, 16'h0012);
        chk(code14, 16'h0012);
        $display("reset and recovery done");
        {l16, l12, b16, b12} = {nl16, nl12, na16, na12};
        // select rises in the same step as the final fall
        host.send(24'h00beef, 24, -1);
        chk(code16, 16'hbeef);
        chk(code12, 16'h00be);
        chk(code14, 16'h00be);
        chk({nl16 - l16, na16 - b16, nl12 - l12, na12 - b12}, 16'h1010);
        $display("select rise on final edge done");
        host.send(24'hffffff, 24, 99);
        chk(code16, 16'hffff);
        chk(code14, 16'h3fff);
        chk(code12, 16'h0fff);
        $display("full scale done");
        report_and_stop();
    end
endmodule
`default_nettype wire
